// >>> rtl/sps_consts.vh
// Constants for the step program sequencer: register map, field codes, timing
`ifndef SPS_CONSTS_VH
`define SPS_CONSTS_VH

// ****************************************************************
// Register byte offsets (APB, one 32-bit word each)
// ****************************************************************
`define SPS_REG_CTRL      12'h0_000
`define SPS_REG_STEPIDX   12'h0_004
`define SPS_REG_VSET      12'h0_008
`define SPS_REG_ISET      12'h0_00C
`define SPS_REG_OVT       12'h0_010
`define SPS_REG_OCT       12'h0_014
`define SPS_REG_PERIOD    12'h0_018
`define SPS_REG_STATUS    12'h0_01C
`define SPS_REG_CONFIG    12'h0_020

// ****************************************************************
// Control register bits (write one to trigger)
// ****************************************************************
`define SPS_CTRL_ARM      0
`define SPS_CTRL_START    1
`define SPS_CTRL_STOP     2
`define SPS_CTRL_CLEAR    3

// ****************************************************************
// Step memory geometry and special period codes
// ****************************************************************
`define SPS_STEPS         7'd100
`define SPS_LAST_STEP     7'd99
`define SPS_PANEL_STEPS   7'd10
`define SPS_PER_STANDBY   14'd0
`define SPS_PER_JUMP0     14'd9998
`define SPS_PER_HOLD      14'd9999
`define SPS_DISP_EXT      4'hE

// ****************************************************************
// Ratings, defaults and trip maxima (110 percent)
// ****************************************************************
`define SPS_RATED_V       16'd10000
`define SPS_RATED_I       16'd5000
`define SPS_TRIP_V_MAX    16'd11000
`define SPS_TRIP_I_MAX    16'd5500
`define SPS_DEF_PERIOD    14'd0

// ****************************************************************
// Run states, menu items and reference modes
// ****************************************************************
`define SPS_ST_STANDBY    3'd0
`define SPS_ST_CLOSING    3'd1
`define SPS_ST_POWER      3'd2
`define SPS_ST_OPENING    3'd3
`define SPS_ST_ALARM      3'd4
`define SPS_ITEM_SENSE    3'd0
`define SPS_ITEM_PANEL    3'd1
`define SPS_ITEM_REAR     3'd2
`define SPS_ITEM_ROTARY   3'd3
`define SPS_ITEM_ANALOG   3'd4
`define SPS_ITEM_REMOTE   3'd5
`define SPS_ITEM_ILOCK    3'd6
`define SPS_REF_ROTARY    2'd0
`define SPS_REF_ANALOG    2'd1
`define SPS_REF_REMOTE    2'd2

// ****************************************************************
// Timing: clock, contactor settle time, step base tick
// ****************************************************************
`define SPS_CLK_MHZ       100
`define SPS_CONTACT_US    20
`define SPS_CONTACT_CYC   (`SPS_CONTACT_US * `SPS_CLK_MHZ)
`define SPS_TICK_MS       10
`define SPS_TICK_CYC      (`SPS_TICK_MS * 1000 * `SPS_CLK_MHZ)

`endif

// >>> rtl/sps_ctrl.v
// Step program sequencer control: step memory, run states, menu, display, APB slave
// How it works
// - Store V, I, trips, period per 100 steps
// - Panel edits steps 0-9; bus edits 0-99
// - Steps 10-99 show extended character
// - Setpoints default zero, clamp to rating
// - Trips default and clamp to 110 percent
// - Start accepted only once armed
// - Start runs program applying each step
// - Advance on period expiry or start
// - Period zero puts output to standby
// - Period 9999 holds step on continuously
// - Period 9998 jumps back to step zero
// - Stop halts sequence at any step
// - Start after stop resumes current step
// - Memory-set key selects or advances step
// - Contactors close before power stages enable
// - Stop disables stages, then opens contactors
// - Hold keys show setpoints or trip levels
// - Menu only in standby or alarm
// - Item key cycles seven options, wraps
// - Enter sets, clear resets flag options
// - Panel and rear flags gate their controls
// - Interlock enabled needs closed loop to run
// - Reference mode exclusive; clear leaves unchanged
`timescale 1ns/1ns
`include "sps_consts.vh"

module sps_ctrl #(
	parameter TICK_CYCLES = `SPS_TICK_CYC
) (
	// Clock and reset
	input  wire        clk,
	input  wire        rst_n,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Front panel keys (pulses except the two view keys)
	input  wire        keyArm,
	input  wire        keyStart,
	input  wire        keyStop,
	input  wire        keyClear,
	input  wire        keyMemSet,
	input  wire        keyMenu,
	input  wire        keyItem,
	input  wire        keyEnter,
	input  wire        keySetView,
	input  wire        keyTripView,
	// Panel edit of the active step
	input  wire        editStrobe,
	input  wire [2:0]  editField,
	input  wire [15:0] editValue,
	// Rear contact inputs (pulses) and interlock level
	input  wire        rearArm,
	input  wire        rearStart,
	input  wire        rearStop,
	input  wire        rearClear,
	input  wire        interlockClosed,
	// Measured output for display
	input  wire [15:0] measVolt,
	input  wire [15:0] measCurr,
	// Power path
	output reg         contactorOn,
	output reg         stageEnable,
	output reg  [15:0] voltSet,
	output reg  [15:0] currSet,
	output reg  [15:0] overvoltageTripLevel,
	output reg  [15:0] overcurrentTripLevel,
	// Display and configuration
	output reg  [15:0] dispVolt,
	output reg  [15:0] dispCurr,
	output reg  [3:0]  dispMem,
	output reg         configureMenuPrompt,
	output reg  [2:0]  menuItem,
	output reg         senseRemote,
	output reg  [1:0]  refMode,
	output reg  [2:0]  runState,
	output reg         armed
);

	// ****************************************************************
	// Functions
	// ****************************************************************
	// Clamp a value to its maximum
	function [15:0] clampTo;
		input [15:0] value;
		input [15:0] maxValue;
		begin
			clampTo = (value > maxValue) ? maxValue : value;
		end
	endfunction

	// Next step index with wrap after the last step
	function [6:0] nextStep;
		input [6:0] step;
		begin
			nextStep = (step >= `SPS_LAST_STEP) ? 7'd0 : step + 7'd1;
		end
	endfunction

	// ****************************************************************
	// Reset release
	// ****************************************************************
	reg rstMeta;
	reg rstSync;

	// Async assert, release through two flops
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta <= 1'b0;
			rstSync <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstSync <= rstMeta;
		end
	end

	// ****************************************************************
	// Declarations
	// ****************************************************************
	reg  [15:0] memV   [0:99];
	reg  [15:0] memI   [0:99];
	reg  [15:0] memOvt [0:99];
	reg  [15:0] memOct [0:99];
	reg  [13:0] memPer [0:99];
	reg  [6:0]  editIdx;
	reg  [6:0]  activeStep;
	reg         stepEval;
	reg         timerOn;
	reg  [13:0] timerCnt;
	reg  [31:0] tickCnt;
	reg  [11:0] contactCnt;
	reg         panelEn;
	reg         rearEn;
	reg         ilockEn;
	reg         menuOn;
	reg  [31:0] rdMux;
	reg         rdErr;
	integer     i;

	wire        apbWr     = psel & penable & pwrite & pready;   // Lands at the completing edge
	wire        swCtrlWr  = apbWr && (paddr == `SPS_REG_CTRL);
	// Control sources: panel, rear contacts, and the bus as remote
	wire        doArm     = (panelEn & keyArm) | (rearEn & rearArm)
	                        | (swCtrlWr & pwdata[`SPS_CTRL_ARM]);
	wire        doStart   = (panelEn & keyStart) | (rearEn & rearStart)
	                        | (swCtrlWr & pwdata[`SPS_CTRL_START]);
	wire        doStop    = (panelEn & keyStop) | (rearEn & rearStop)
	                        | (swCtrlWr & pwdata[`SPS_CTRL_STOP]);
	wire        doClear   = (panelEn & keyClear) | (rearEn & rearClear)
	                        | (swCtrlWr & pwdata[`SPS_CTRL_CLEAR]);
	wire        ilockOk   = ~ilockEn | interlockClosed;
	wire        tick      = (tickCnt == TICK_CYCLES - 1);
	wire        idleState = (runState == `SPS_ST_STANDBY) || (runState == `SPS_ST_ALARM);
	wire        panelEdit = editStrobe && (activeStep < `SPS_PANEL_STEPS);

	// ****************************************************************
	// Step memory
	// ****************************************************************
	// Bus writes go to the edit index, panel edits to the active step
	always @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			for (i = 0; i < 100; i = i + 1) begin
				memV[i]   <= 16'h0_000;
				memI[i]   <= 16'h0_000;
				memOvt[i] <= `SPS_TRIP_V_MAX;
				memOct[i] <= `SPS_TRIP_I_MAX;
				memPer[i] <= `SPS_DEF_PERIOD;
			end
			editIdx <= 7'd0;
		end else begin
			// Panel edit first so a bus write to the same step wins
			if (panelEdit) begin
				case (editField)
					3'd0: memV[activeStep]   <= clampTo(editValue, `SPS_RATED_V);
					3'd1: memI[activeStep]   <= clampTo(editValue, `SPS_RATED_I);
					3'd2: memOvt[activeStep] <= clampTo(editValue, `SPS_TRIP_V_MAX);
					3'd3: memOct[activeStep] <= clampTo(editValue, `SPS_TRIP_I_MAX);
					3'd4: memPer[activeStep] <= editValue[13:0];
					default: ;
				endcase
			end
			if (apbWr) begin
				case (paddr)
					`SPS_REG_STEPIDX: editIdx <= (pwdata[6:0] > `SPS_LAST_STEP) ?
					                             `SPS_LAST_STEP : pwdata[6:0];
					`SPS_REG_VSET:    memV[editIdx]   <= clampTo(pwdata[15:0], `SPS_RATED_V);
					`SPS_REG_ISET:    memI[editIdx]   <= clampTo(pwdata[15:0], `SPS_RATED_I);
					`SPS_REG_OVT:     memOvt[editIdx] <= clampTo(pwdata[15:0], `SPS_TRIP_V_MAX);
					`SPS_REG_OCT:     memOct[editIdx] <= clampTo(pwdata[15:0], `SPS_TRIP_I_MAX);
					`SPS_REG_PERIOD:  memPer[editIdx] <= pwdata[13:0];
					default: ;
				endcase
			end
		end
	end

	// ****************************************************************
	// Base tick divider
	// ****************************************************************
	// Free running so a period is accurate to one tick
	always @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			tickCnt <= 32'h0000_0000;
		end else if (tick) begin
			tickCnt <= 32'h0000_0000;
		end else begin
			tickCnt <= tickCnt + 32'h0000_0001;
		end
	end

	// ****************************************************************
	// Run state machine and sequencing
	// ****************************************************************
	// Stop outranks start; an open interlock outranks both
	always @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			runState    <= `SPS_ST_STANDBY;
			armed       <= 1'b0;
			activeStep  <= 7'd0;
			stepEval    <= 1'b0;
			timerOn     <= 1'b0;
			timerCnt    <= 14'd0;
			contactCnt  <= 12'd0;
			contactorOn <= 1'b0;
			stageEnable <= 1'b0;
		end else begin
			if (doArm) begin
				armed <= 1'b1;
			end
			case (runState)
				`SPS_ST_STANDBY: begin
					// Arm in the same cycle as clear wins
					if (doClear && !doArm) begin
						armed <= 1'b0;
					end
					if (keyMemSet && !menuOn) begin
						activeStep <= nextStep(activeStep);
					end
					// Resumes at the step where it stopped
					if (doStart && armed && ilockOk && !doStop) begin
						runState    <= `SPS_ST_CLOSING;
						contactorOn <= 1'b1;
						contactCnt  <= 12'd0;
					end
				end
				`SPS_ST_CLOSING: begin
					contactCnt <= contactCnt + 12'd1;
					if (doStop || !ilockOk) begin
						runState    <= `SPS_ST_OPENING;
						contactCnt  <= 12'd0;
					end else if (contactCnt == `SPS_CONTACT_CYC - 1) begin
						runState    <= `SPS_ST_POWER;
						stageEnable <= 1'b1;
						stepEval    <= 1'b1;
					end
				end
				`SPS_ST_POWER: begin
					if (!ilockOk) begin
						runState    <= `SPS_ST_ALARM;
						stageEnable <= 1'b0;
						contactorOn <= 1'b0;
						timerOn     <= 1'b0;
						stepEval    <= 1'b0;
					end else if (doStop) begin
						runState    <= `SPS_ST_OPENING;
						stageEnable <= 1'b0;
						contactCnt  <= 12'd0;
						timerOn     <= 1'b0;
						stepEval    <= 1'b0;
					end else if (stepEval) begin
						stepEval <= 1'b0;
						timerOn  <= 1'b0;
						case (memPer[activeStep])
							`SPS_PER_STANDBY: begin
								runState    <= `SPS_ST_OPENING;
								stageEnable <= 1'b0;
								contactCnt  <= 12'd0;
							end
							`SPS_PER_HOLD: ;
							`SPS_PER_JUMP0: begin
								activeStep <= 7'd0;
								stepEval   <= 1'b1;
							end
							default: begin
								timerOn  <= 1'b1;
								timerCnt <= memPer[activeStep];
							end
						endcase
					end else if (doStart || keyMemSet ||
					             (timerOn && tick && timerCnt == 14'd1)) begin
						activeStep <= nextStep(activeStep);
						stepEval   <= 1'b1;
						timerOn    <= 1'b0;
					end else if (timerOn && tick) begin
						timerCnt <= timerCnt - 14'd1;
					end
				end
				`SPS_ST_OPENING: begin
					// Stages are already off; let them settle before opening contactors
					stageEnable <= 1'b0;
					contactCnt  <= contactCnt + 12'd1;
					if (contactCnt == `SPS_CONTACT_CYC - 1) begin
						runState    <= `SPS_ST_STANDBY;
						contactorOn <= 1'b0;
					end
				end
				`SPS_ST_ALARM: begin
					if (keyMemSet && !menuOn) begin
						activeStep <= nextStep(activeStep);
					end
					if (doClear && ilockOk) begin
						runState <= `SPS_ST_STANDBY;
					end
				end
				default: begin
					runState    <= `SPS_ST_STANDBY;
					contactorOn <= 1'b0;
					stageEnable <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************************************
	// Configuration menu
	// ****************************************************************
	// Any menu key outside standby or alarm is dropped
	always @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			menuOn      <= 1'b0;
			menuItem    <= `SPS_ITEM_SENSE;
			senseRemote <= 1'b0;
			panelEn     <= 1'b1;
			rearEn      <= 1'b1;
			ilockEn     <= 1'b0;
			refMode     <= `SPS_REF_ROTARY;
		end else if (!idleState) begin
			menuOn <= 1'b0;
		end else if (!menuOn) begin
			if (keyMenu) begin
				menuOn   <= 1'b1;
				menuItem <= `SPS_ITEM_SENSE;
			end
		end else if (keyMenu) begin
			menuOn <= 1'b0;
		end else if (keyItem) begin
			menuItem <= (menuItem == `SPS_ITEM_ILOCK) ? `SPS_ITEM_SENSE :
			            menuItem + 3'd1;
		end else if (keyEnter || keyClear) begin
			case (menuItem)
				`SPS_ITEM_SENSE: senseRemote <= keyEnter;
				`SPS_ITEM_PANEL: panelEn     <= keyEnter;
				`SPS_ITEM_REAR:  rearEn      <= keyEnter;
				`SPS_ITEM_ILOCK: ilockEn     <= keyEnter;
				`SPS_ITEM_ROTARY, `SPS_ITEM_ANALOG, `SPS_ITEM_REMOTE: begin
					// Enter replaces the mode, clear leaves it; both exit
					if (keyEnter) begin
						refMode <= (menuItem == `SPS_ITEM_ROTARY) ? `SPS_REF_ROTARY :
						           (menuItem == `SPS_ITEM_ANALOG) ? `SPS_REF_ANALOG :
						           `SPS_REF_REMOTE;
					end
					menuOn <= 1'b0;
				end
				default: menuOn <= 1'b0;
			endcase
		end
	end

	// ****************************************************************
	// Applied parameters and display
	// ****************************************************************
	// Registered so every output is a flop
	always @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			voltSet              <= 16'h0_000;
			currSet              <= 16'h0_000;
			overvoltageTripLevel <= `SPS_TRIP_V_MAX;
			overcurrentTripLevel <= `SPS_TRIP_I_MAX;
			dispVolt             <= 16'h0_000;
			dispCurr             <= 16'h0_000;
			dispMem              <= 4'h0;
			configureMenuPrompt  <= 1'b0;
		end else begin
			voltSet              <= memV[activeStep];
			currSet              <= memI[activeStep];
			overvoltageTripLevel <= memOvt[activeStep];
			overcurrentTripLevel <= memOct[activeStep];
			dispMem              <= (activeStep >= `SPS_PANEL_STEPS) ? `SPS_DISP_EXT :
			                        activeStep[3:0];
			configureMenuPrompt  <= menuOn;
			if (keySetView) begin
				dispVolt <= memV[activeStep];
				dispCurr <= memI[activeStep];
			end else if (keyTripView) begin
				dispVolt <= memOvt[activeStep];
				dispCurr <= memOct[activeStep];
			end else begin
				dispVolt <= measVolt;
				dispCurr <= measCurr;
			end
		end
	end

	// ****************************************************************
	// APB read mux and answer
	// ****************************************************************
	// Read data for the addressed register
	always @* begin
		rdMux = 32'h0000_0000;
		rdErr = 1'b0;
		case (paddr)
			`SPS_REG_CTRL:    rdMux = 32'h0000_0000;
			`SPS_REG_STEPIDX: rdMux = {25'd0, editIdx};
			`SPS_REG_VSET:    rdMux = {16'd0, memV[editIdx]};
			`SPS_REG_ISET:    rdMux = {16'd0, memI[editIdx]};
			`SPS_REG_OVT:     rdMux = {16'd0, memOvt[editIdx]};
			`SPS_REG_OCT:     rdMux = {16'd0, memOct[editIdx]};
			`SPS_REG_PERIOD:  rdMux = {18'd0, memPer[editIdx]};
			`SPS_REG_STATUS:  rdMux = {16'd0, timerOn, stageEnable, contactorOn, armed,
			                           runState, 2'd0, activeStep};
			`SPS_REG_CONFIG:  rdMux = {24'd0, menuOn, refMode, ilockEn, rearEn, panelEn,
			                           1'b0, senseRemote};
			default:          rdErr = 1'b1;
		endcase
	end

	// One wait state: pready rises in the second access cycle
	always @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & rdErr;
			prdata  <= (psel & penable & ~pready & ~pwrite) ? rdMux : 32'h0000_0000;
		end
	end

endmodule // sps_ctrl

// >>> testbench/sps_ctrl_props.sv
// Checker: timing relations watched at the sequencer's ports
`timescale 1ns/1ns
`include "sps_consts.vh"
module sps_ctrl_props (
	// Clock, reset and APB handshake
	input wire        clk,
	input wire        rst_n,
	input wire        psel,
	input wire        penable,
	input wire        pready,
	// Run state and power path
	input wire        armed,
	input wire        contactorOn,
	input wire        stageEnable,
	input wire [2:0]  runState,
	input wire [15:0] voltSet,
	input wire [15:0] currSet,
	input wire [15:0] overvoltageTripLevel,
	input wire [15:0] overcurrentTripLevel,
	// Display and menu
	input wire [3:0]  dispMem,
	input wire        configureMenuPrompt,
	input wire [2:0]  menuItem
);
	// ******
	// Assertions, one clock domain
	// ******
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	a_apb_wait: assert property (psel && penable && !pready |=> pready)
		else $error("access not answered after one wait state");
	a_arm_first: assert property ($rose(contactorOn) |-> $past(armed))
		else $error("contactors closed while not armed");
	a_close_first: assert property ($rose(contactorOn) |-> !stageEnable [*8])
		else $error("stages enabled too soon after contactors");
	a_stage_contact: assert property (stageEnable |-> contactorOn)
		else $error("stages enabled with contactors open");
	a_stop_order: assert property ($fell(stageEnable) && runState == `SPS_ST_OPENING |-> contactorOn [*8])
		else $error("contactors opened before stages settled off");
	a_ext_char: assert property (dispMem <= 4'h9 || dispMem == `SPS_DISP_EXT)
		else $error("memory display shows an illegal code");
	a_menu_state: assert property ($changed(menuItem) |->
		$past(runState) == `SPS_ST_STANDBY || $past(runState) == `SPS_ST_ALARM)
		else $error("menu moved outside standby or alarm");
	a_item_wrap: assert property ($changed(menuItem) && $past(configureMenuPrompt) && configureMenuPrompt |->
		menuItem == ($past(menuItem) == 3'd6 ? 3'd0 : $past(menuItem) + 3'd1))
		else $error("menu option out of order");
	a_set_clamp: assert property (voltSet <= `SPS_RATED_V && currSet <= `SPS_RATED_I)
		else $error("setpoint above rating");
	a_trip_clamp: assert property (overvoltageTripLevel <= `SPS_TRIP_V_MAX && overcurrentTripLevel <= `SPS_TRIP_I_MAX)
		else $error("trip level above maximum");
endmodule // sps_ctrl_props

// >>> testbench/sps_ctrl_tb_top.sv
// Testbench top: APB and key sequences for the step program sequencer
`timescale 1ns/1ns
`include "sps_consts.vh"
module sps_ctrl_tb_top;
	// ******
	// Signals and instances
	// ******
	logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000, keys;
	logic [31:0] pwdata = 32'h0000_0000, prdata, q;
	logic        pready, pslverr, err, cOn, sEn, prompt, sense, armed, sv, tv, il;
	logic [15:0] vSet, iSet, vTrip, iTrip, dV, dI;
	logic [3:0]  dMem;
	logic        eStb = 1'b0;
	logic [2:0]  eFld = 3'h0;
	logic [15:0] eVal = 16'h0000, mV = 16'h0123, mI = 16'h0045;
	logic [2:0]  item, run;
	logic [1:0]  refSel;
	int          n_errors = 0, checks_done = 0;
	// Short base tick keeps step periods brief
	sps_ctrl #(.TICK_CYCLES(4)) dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.keyArm(keys[0]), .keyStart(keys[1]), .keyStop(keys[2]), .keyClear(keys[3]), .keyMemSet(keys[4]),
		.keyMenu(keys[5]), .keyItem(keys[6]), .keyEnter(keys[7]), .keySetView(sv), .keyTripView(tv),
		.editStrobe(eStb), .editField(eFld), .editValue(eVal), .rearArm(keys[8]), .rearStart(keys[9]),
		.rearStop(keys[10]), .rearClear(keys[11]), .interlockClosed(il), .measVolt(mV),
		.measCurr(mI), .contactorOn(cOn), .stageEnable(sEn), .voltSet(vSet), .currSet(iSet),
		.overvoltageTripLevel(vTrip), .overcurrentTripLevel(iTrip), .dispVolt(dV), .dispCurr(dI),
		.dispMem(dMem), .configureMenuPrompt(prompt), .menuItem(item), .senseRemote(sense),
		.refMode(refSel), .runState(run), .armed(armed));
	sps_panel_model pm_u (.clk(clk), .keys(keys), .keySetView(sv), .keyTripView(tv), .interlockClosed(il));
	// 100 MHz clock
	initial begin
		forever #5 clk = ~clk;
	end
	// ******
	// Tasks
	// ******
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Setup, then access held until pready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			n_errors++;
			tally_and_finish;
		end
	endtask
	// Bounded wait for a run state
	task wait_run(input logic [2:0] s);
		int n;
		n = 0;
		while (run !== s && n < 5000) begin
			@(posedge clk);
			n++;
		end
		if (run !== s) begin
			n_errors++;
			tally_and_finish;
		end
	endtask
	task set_step(input logic [31:0] idx, input logic [31:0] v, input logic [31:0] p);
		apb(1'b1, `SPS_REG_STEPIDX, idx);
		apb(1'b1, `SPS_REG_VSET, v);
		apb(1'b1, `SPS_REG_PERIOD, p);
	endtask
	task step_is(input logic [31:0] s);
		apb(1'b0, `SPS_REG_STATUS, 32'h0000_0000);
		chk("active step", q & 32'h0000_007F, s);
	endtask
	// One-cycle panel edit of the active step, then settle
	task edit(input logic [2:0] f, input logic [15:0] v);
		@(posedge clk);
		eStb <= 1'b1;
		eFld <= f;
		eVal <= v;
		@(posedge clk);
		eStb <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	// ******
	// Main sequence
	// ******
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		chk("trip v reset", vTrip, `SPS_TRIP_V_MAX);
		chk("trip i reset", iTrip, `SPS_TRIP_I_MAX);
		apb(1'b0, `SPS_REG_VSET, 32'h0000_0000);
		chk("v default", q, 32'h0000_0000);
		apb(1'b1, `SPS_REG_OCT, 32'h0000_FFFF);
		apb(1'b0, `SPS_REG_OCT, 32'h0000_0000);
		chk("trip i clamp", q, `SPS_TRIP_I_MAX);
		apb(1'b1, `SPS_REG_STEPIDX, 32'h0000_007F);
		apb(1'b1, `SPS_REG_VSET, 32'h0000_FFFF);
		apb(1'b0, `SPS_REG_VSET, 32'h0000_0000);
		chk("v clamp step 99", q, `SPS_RATED_V);
		apb(1'b0, 12'h0_0FC, 32'h0000_0000);
		chk("unmapped", err, 1'b1);
		set_step(0, 100, 3);
		set_step(1, 200, 9999);
		set_step(2, 300, 0);
		pm_u.press(1);
		chk("start unarmed", run, `SPS_ST_STANDBY);
		pm_u.press(0);
		pm_u.press(1);
		wait_run(`SPS_ST_POWER);
		chk("power path on", {cOn, sEn}, 2'b11);
		repeat (100) @(posedge clk);
		step_is(1);
		chk("v step 1", vSet, 200);
		pm_u.hold(1'b1, 1'b0, 1'b1);
		chk("view setpoint", {dV, dI}, {16'd200, 16'd0});
		pm_u.hold(1'b0, 1'b1, 1'b1);
		chk("view trip", {dV, dI}, {`SPS_TRIP_V_MAX, `SPS_TRIP_I_MAX});
		mV <= 16'h0456;
		mI <= 16'h0078;
		pm_u.hold(1'b0, 1'b0, 1'b1);
		chk("view actual", {dV, dI}, {16'h0456, 16'h0078});
		pm_u.press(5);
		chk("menu in power", prompt, 1'b0);
		pm_u.press(2);
		wait_run(`SPS_ST_STANDBY);
		chk("power path off", {cOn, sEn}, 2'b00);
		step_is(1);
		pm_u.press(1);
		wait_run(`SPS_ST_POWER);
		step_is(1);
		pm_u.press(1);
		wait_run(`SPS_ST_STANDBY);
		step_is(2);
		set_step(2, 300, 9998);
		pm_u.press(1);
		wait_run(`SPS_ST_POWER);
		repeat (100) @(posedge clk);
		step_is(1);
		pm_u.press(2);
		wait_run(`SPS_ST_STANDBY);
		pm_u.press(4);
		chk("memset params", vSet, 300);
		repeat (7) pm_u.press(4);
		chk("mem 9", dMem, 4'h9);
		edit(3'd0, 16'hFFFF);
		edit(3'd1, 16'hFFFF);
		edit(3'd2, 16'h04D2);
		chk("panel edit v i", {vSet, iSet}, {`SPS_RATED_V, `SPS_RATED_I});
		chk("panel edit trip", vTrip, 16'h04D2);
		pm_u.press(4);
		chk("mem extended", dMem, `SPS_DISP_EXT);
		edit(3'd0, 16'h0007);
		chk("far step edit", vSet, 16'h0000);
		pm_u.press(5);
		repeat (7) pm_u.press(6);
		chk("item wrap", item, `SPS_ITEM_SENSE);
		pm_u.press(7);
		chk("sense set", sense, 1'b1);
		pm_u.press(3);
		chk("sense reset", sense, 1'b0);
		repeat (4) pm_u.press(6);
		pm_u.press(7);
		chk("ref analog", refSel, `SPS_REF_ANALOG);
		pm_u.press(5);
		repeat (5) pm_u.press(6);
		pm_u.press(3);
		chk("ref kept", {prompt, refSel}, {1'b0, `SPS_REF_ANALOG});
		pm_u.press(5);
		pm_u.press(6);
		pm_u.press(3);
		pm_u.press(5);
		apb(1'b1, `SPS_REG_CTRL, 32'h0000_0008);
		pm_u.press(0);
		chk("panel arm gated", armed, 1'b0);
		pm_u.press(8);
		chk("rear arm", armed, 1'b1);
		pm_u.press(5);
		repeat (6) pm_u.press(6);
		pm_u.press(7);
		pm_u.press(5);
		pm_u.hold(1'b0, 1'b0, 1'b0);
		pm_u.press(9);
		chk("loop open start", run, `SPS_ST_STANDBY);
		pm_u.hold(1'b0, 1'b0, 1'b1);
		pm_u.press(9);
		wait_run(`SPS_ST_POWER);
		tally_and_finish;
	end
endmodule // sps_ctrl_tb_top
bind sps_ctrl sps_ctrl_props chk_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready),
	.armed(armed), .contactorOn(contactorOn), .stageEnable(stageEnable), .runState(runState), .voltSet(voltSet),
	.currSet(currSet), .overvoltageTripLevel(overvoltageTripLevel), .overcurrentTripLevel(overcurrentTripLevel),
	.dispMem(dispMem), .configureMenuPrompt(configureMenuPrompt), .menuItem(menuItem));

// >>> testbench/sps_panel_model.sv
// Partner model: panel keys [7:0] arm start stop clear memset menu item enter, rear [11:8] arm start stop clear
`timescale 1ns/1ns
module sps_panel_model (
	// Clock
	input  wire         clk,
	// Key and contact pulses, held levels
	output logic [11:0] keys,
	output logic        keySetView,
	output logic        keyTripView,
	output logic        interlockClosed
);
	// Idle contacts open, loop closed
	initial begin
		keys = 12'h000;
		keySetView = 1'b0;
		keyTripView = 1'b0;
		interlockClosed = 1'b1;
	end
	// One-cycle press, then a pause so registered outputs settle
	task press(input int id);
		@(posedge clk);
		keys[id] <= 1'b1;
		@(posedge clk);
		keys[id] <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	// Held keys and loop level change together
	task hold(input logic sv, input logic tv, input logic il);
		@(posedge clk);
		keySetView <= sv;
		keyTripView <= tv;
		interlockClosed <= il;
		repeat (4) @(posedge clk);
	endtask
endmodule // sps_panel_model
